/* File: rtl/serial_port_pkg.sv */
/*
  Constants, register map and state types for the configurable serial port.
  Assumes a single 50 MHz system clock and a classic Wishbone register bus.
*/
package serial_port_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_RATE_HZ = 50_000_000;
  localparam int unsigned WAIT_STEP_MS = 100;
  localparam int unsigned MS_PER_S = 1000;
  localparam logic [8:0] WAIT_MAX_STEPS = 9'h12C;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_WAIT = 5'h04;
  localparam logic [4:0] OFS_TXDATA = 5'h08;
  localparam logic [4:0] OFS_RXDATA = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_ST = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
  localparam logic [4:0] OFS_MEMSW = 5'h1C;

  // ---------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------
  localparam int CTRL_EXPLICIT = 0;
  localparam int CTRL_RATE_LO = 1;
  localparam int CTRL_PAR_LO = 4;
  localparam int CTRL_LEN7 = 6;
  localparam int CTRL_STOP2 = 7;
  localparam int CTRL_NO_SOFT_FLOW = 8;
  localparam int CTRL_RTS_IO_GATING = 9;
  localparam int CTRL_SKIP_MODEM_READY = 10;
  localparam int CTRL_LF_INSERT = 11;
  localparam int CTRL_TERM_PORT = 12;
  localparam int CTRL_IO_ACTIVE = 13;
  localparam int CTRL_WIDTH = 14;
  localparam logic [13:0] CTRL_RESET = 14'h0000;

  // Parity codes.
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;

  // Rate codes; code 0 means "not given".
  localparam logic [2:0] RATE_UNSET = 3'h0;
  localparam logic [2:0] RATE_9600 = 3'h6;
  localparam logic [2:0] MEMSW_RESET = 3'h0;

  // ---------------------------------------------------------------------
  // Interrupt status bits
  // ---------------------------------------------------------------------
  localparam int IRQ_RX_READY = 0;
  localparam int IRQ_PARITY_ERR = 1;
  localparam int IRQ_FRAME_ERR = 2;
  localparam int IRQ_TIMEOUT_ERR = 3;
  localparam int IRQ_NOT_READY_ERR = 4;
  localparam int IRQ_TX_DONE = 5;
  localparam int IRQ_WIDTH = 6;
  localparam logic [5:0] IRQ_RESET = 6'h00;

  // Control characters.
  localparam logic [7:0] CHAR_RESUME = 8'h11;
  localparam logic [7:0] CHAR_STOP = 8'h13;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;

  // ---------------------------------------------------------------------
  // State machines
  // ---------------------------------------------------------------------
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } rx_state_t;

endpackage

/* File: rtl/configurable_serial_port_ctl.sv */
/*
  Asynchronous serial port with per-open settings, soft flow control,
  request-to-send gating, clear-to-send send monitoring and line-feed
  insertion, reached over a classic Wishbone slave.
  Assumes one clock, a synchronous active-high reset and asynchronous
  line inputs, which are synchronised here.
*/
// Implementation choices: the Wishbone register port and the placing of the registers.
// How it works
// - Seven line rates from 300 to 19200 bits per second are selectable.
// - Parity even, odd or none; none by default.
// - Characters have 7 or 8 data bits; 8 by default.
// - One or two stop bits are sent; two by default.
// - Without explicit settings: 8 bits, 2 stops, no soft flow.
// - Soft flow pauses and resumes sending on received control characters.
// - Gated request-to-send follows I/O activity, otherwise stays asserted.
// - Gating is never applied on the terminal or printer port.
// - Send only under clear-to-send, with a 100 ms step wait limit.
// - Wait expiry or clear-to-send loss mid character aborts with a timeout error.
// - Data-set-ready is checked unless the skip option is set.
// - Missing data-set-ready raises a not-ready error instead of transfer.
// - Optional line feed is sent after every carriage return.
`timescale 1ns/1ps
module configurable_serial_port_ctl
  import serial_port_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLK_RATE_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd_i,
  input wire logic cts_i,
  input wire logic dsr_i,
  output logic txd_o,
  output logic rts_o,
  output logic irq_o
);

  localparam logic [23:0] STEP_CYC =
    24'(CLK_HZ / MS_PER_S * WAIT_STEP_MS - 1);

  function automatic logic [17:0] bit_div(input logic [2:0] code);
    int unsigned bps;
    bps = 9600;
    unique case (code)
      3'h1: bps = 300;
      3'h2: bps = 600;
      3'h3: bps = 1200;
      3'h4: bps = 2400;
      3'h5: bps = 4800;
      3'h6: bps = 9600;
      3'h7: bps = 19200;
      default: bps = 9600;
    endcase
    return 18'(CLK_HZ / bps - 1);
  endfunction

  // ---------------------------------------------------------------------
  // Line input synchronisers
  // ---------------------------------------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic rx_s;
  logic cts_s;
  logic dsr_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
    end else begin
      sync1_r <= {dsr_i, cts_i, rxd_i};
      sync2_r <= sync1_r;
    end
  end
  assign rx_s = sync2_r[0];
  assign cts_s = sync2_r[1];
  assign dsr_s = sync2_r[2];

  // ---------------------------------------------------------------------
  // Registers and effective settings
  // ---------------------------------------------------------------------
  logic [13:0] ctrl_r;
  logic [8:0] wait_r;
  logic [5:0] irq_st_r;
  logic [5:0] irq_mask_r;
  logic [2:0] memsw_r;
  logic [7:0] rx_data_r;
  logic rx_v_r;
  logic paused_r;
  logic hold_v_r;
  logic lf_pend_r;
  logic tx_abort;
  logic tx_busy;
  logic [5:0] ev;
  logic bus_req;
  logic wr;
  logic rd_rx;
  logic wr_tx;
  logic explicit;
  logic [2:0] rate_code;
  logic [17:0] div;
  logic [1:0] par_mode;
  logic len7;
  logic stop2;
  logic soft_flow;
  logic modem_ok;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = bus_req & wb_we_i & wb_sel_i[0];
  assign wr_tx = wr & (wb_adr_i == OFS_TXDATA);
  assign rd_rx = bus_req & ~wb_we_i & (wb_adr_i == OFS_RXDATA);
  assign explicit = ctrl_r[CTRL_EXPLICIT];

  assign rate_code = (explicit && ctrl_r[CTRL_RATE_LO+:3] != RATE_UNSET)
    ? ctrl_r[CTRL_RATE_LO+:3]
    : (memsw_r != RATE_UNSET) ? memsw_r : RATE_9600;
  assign div = bit_div(rate_code);
  assign par_mode = explicit ? ctrl_r[CTRL_PAR_LO+:2] : PAR_NONE;
  assign len7 = explicit & ctrl_r[CTRL_LEN7];
  assign stop2 = explicit ? ctrl_r[CTRL_STOP2] : 1'b1;
  assign soft_flow = explicit & ~ctrl_r[CTRL_NO_SOFT_FLOW];
  assign modem_ok = (explicit & ctrl_r[CTRL_SKIP_MODEM_READY]) | dsr_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
      wait_r <= 9'h000;
      irq_mask_r <= IRQ_RESET;
      memsw_r <= MEMSW_RESET;
    end else if (wr) begin
      unique case (wb_adr_i)
        OFS_CTRL: ctrl_r <= wb_dat_i[CTRL_WIDTH-1:0];
        OFS_WAIT: wait_r <= (|wb_dat_i[31:9] ||
          wb_dat_i[8:0] > WAIT_MAX_STEPS) ?
          WAIT_MAX_STEPS : wb_dat_i[8:0];
        OFS_IRQ_MASK: irq_mask_r <= wb_dat_i[IRQ_WIDTH-1:0];
        OFS_MEMSW: memsw_r <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  // Sticky status; a new event wins over a write-one clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_r <= IRQ_RESET;
      irq_o <= 1'b0;
    end else begin
      if (wr && wb_adr_i == OFS_IRQ_ST) begin
        irq_st_r <= (irq_st_r & ~wb_dat_i[IRQ_WIDTH-1:0]) | ev;
      end else begin
        irq_st_r <= irq_st_r | ev;
      end
      irq_o <= |(irq_st_r & irq_mask_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        unique case (wb_adr_i)
          OFS_CTRL: wb_dat_o <= {18'h00000, ctrl_r};
          OFS_WAIT: wb_dat_o <= {23'h000000, wait_r};
          OFS_RXDATA: wb_dat_o <= {24'h000000, rx_data_r};
          OFS_STATUS: wb_dat_o <= {26'h0000000, dsr_s, cts_s, paused_r,
            rx_v_r, hold_v_r, tx_busy};
          OFS_IRQ_ST: wb_dat_o <= {26'h0000000, irq_st_r};
          OFS_IRQ_MASK: wb_dat_o <= {26'h0000000, irq_mask_r};
          OFS_MEMSW: wb_dat_o <= {29'h00000000, memsw_r};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------------
  tx_state_t tx_st_r;
  logic [17:0] tx_cnt_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic [7:0] hold_r;
  logic tx_par_r;
  logic tx_tick;
  logic tx_busy_q_r;
  logic tx_go;
  logic [23:0] step_cnt_r;
  logic [8:0] steps_r;
  logic wait_expired;

  assign tx_tick = (tx_cnt_r == 18'h00000);
  assign tx_busy = hold_v_r | lf_pend_r | (tx_st_r != TX_IDLE);
  // start only under clear-to-send and when not paused
  assign tx_go = (hold_v_r | lf_pend_r) & cts_s & ~paused_r;
  assign wait_expired = (wait_r != 9'h000) && (steps_r == wait_r);
  // abort on expiry or clear-to-send loss mid character
  assign tx_abort = tx_busy &
    (wait_expired | (~cts_s & (tx_st_r != TX_IDLE)));

  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_busy || tx_abort) begin
      step_cnt_r <= 24'h000000;
      steps_r <= 9'h000;
    end else if (step_cnt_r == STEP_CYC) begin
      step_cnt_r <= 24'h000000;
      steps_r <= steps_r + 9'h001;
    end else begin
      step_cnt_r <= step_cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r <= TX_IDLE;
      tx_cnt_r <= 18'h00000;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_par_r <= 1'b0;
      txd_o <= 1'b1;
      hold_r <= 8'h00;
      hold_v_r <= 1'b0;
      lf_pend_r <= 1'b0;
    end else begin
      if (wr_tx && !hold_v_r && modem_ok) begin
        hold_r <= wb_dat_i[7:0];
        hold_v_r <= 1'b1;
      end
      tx_cnt_r <= tx_tick ? div : tx_cnt_r - 18'h00001;
      if (tx_abort) begin
        tx_st_r <= TX_IDLE;
        txd_o <= 1'b1;
        hold_v_r <= 1'b0;
        lf_pend_r <= 1'b0;
      end else begin
        unique case (tx_st_r)
          TX_IDLE: begin
            txd_o <= 1'b1;
            if (tx_go) begin
              // pending line feed goes ahead of the next character
              tx_sh_r <= lf_pend_r ? CHAR_LF : hold_r;
              if (lf_pend_r) begin
                lf_pend_r <= 1'b0;
              end else begin
                hold_v_r <= 1'b0;
              end
              tx_cnt_r <= div;
              txd_o <= 1'b0;
              tx_st_r <= TX_START;
            end
          end
          TX_START: begin
            if (tx_tick) begin
              txd_o <= tx_sh_r[0];
              tx_par_r <= (par_mode == PAR_ODD) ^
                (^(len7 ? {1'b0, tx_sh_r[6:0]} : tx_sh_r));
              tx_bit_r <= len7 ? 3'h6 : 3'h7;
              tx_st_r <= TX_DATA;
            end
          end
          TX_DATA: begin
            if (tx_tick) begin
              tx_sh_r <= {tx_sh_r[0], tx_sh_r[7:1]};
              tx_bit_r <= tx_bit_r - 3'h1;
              if (tx_bit_r != 3'h0) begin
                txd_o <= tx_sh_r[1];
              end else if (par_mode != PAR_NONE) begin
                txd_o <= tx_par_r;
                tx_st_r <= TX_PAR;
              end else begin
                txd_o <= 1'b1;
                tx_bit_r <= {2'h0, stop2};
                tx_st_r <= TX_STOP;
              end
            end
          end
          TX_PAR: begin
            if (tx_tick) begin
              txd_o <= 1'b1;
              tx_bit_r <= {2'h0, stop2};
              tx_st_r <= TX_STOP;
            end
          end
          TX_STOP: begin
            if (tx_tick) begin
              tx_bit_r <= tx_bit_r - 3'h1;
              if (tx_bit_r == 3'h0) begin
                tx_st_r <= TX_IDLE;
                if (explicit && ctrl_r[CTRL_LF_INSERT] &&
                    (len7 ? {1'b0, tx_sh_r[7:1]} : tx_sh_r) == CHAR_CR) begin
                  lf_pend_r <= 1'b1;
                end
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rts_o <= 1'b1;
      tx_busy_q_r <= 1'b0;
    end else begin
      tx_busy_q_r <= tx_busy;
      if (explicit && ctrl_r[CTRL_RTS_IO_GATING] &&
          !ctrl_r[CTRL_TERM_PORT]) begin
        rts_o <= tx_busy | ctrl_r[CTRL_IO_ACTIVE];
      end else begin
        rts_o <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------
  rx_state_t rx_st_r;
  logic [17:0] rx_cnt_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_par_bad_r;
  logic rx_tick;
  logic rx_done;
  logic rx_store;
  logic [7:0] rx_char;

  assign rx_tick = (rx_cnt_r == 18'h00000);
  assign rx_done = (rx_st_r == RX_STOP) & rx_tick;
  assign rx_char = len7 ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;
  // flow characters are consumed while soft flow is on
  assign rx_store = rx_done & modem_ok & ~(soft_flow &
    (rx_char == CHAR_STOP || rx_char == CHAR_RESUME));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= 18'h00000;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_bad_r <= 1'b0;
    end else begin
      rx_cnt_r <= rx_tick ? div : rx_cnt_r - 18'h00001;
      unique case (rx_st_r)
        RX_IDLE: begin
          if (!rx_s) begin
            rx_cnt_r <= {1'b0, div[17:1]};
            rx_st_r <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_bit_r <= len7 ? 3'h6 : 3'h7;
            rx_st_r <= rx_s ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_sh_r <= {rx_s, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r - 3'h1;
            if (rx_bit_r == 3'h0) begin
              rx_st_r <= (par_mode != PAR_NONE) ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_tick) begin
            rx_par_bad_r <= rx_s ^ (par_mode == PAR_ODD) ^ (^rx_char);
            rx_st_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_st_r <= RX_IDLE;
          end
        end
      endcase
      if (rx_done) begin
        rx_par_bad_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_r <= 8'h00;
      rx_v_r <= 1'b0;
      paused_r <= 1'b0;
    end else begin
      if (rd_rx) begin
        rx_v_r <= 1'b0;
      end
      if (rx_store) begin
        rx_data_r <= rx_char;
        rx_v_r <= 1'b1;
      end
      // pause and resume on control characters
      if (!soft_flow) begin
        paused_r <= 1'b0;
      end else if (rx_done && rx_char == CHAR_STOP) begin
        paused_r <= 1'b1;
      end else if (rx_done && rx_char == CHAR_RESUME) begin
        paused_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------------
  always_comb begin
    ev = IRQ_RESET;
    ev[IRQ_RX_READY] = rx_store;
    ev[IRQ_PARITY_ERR] = rx_store & rx_par_bad_r;
    ev[IRQ_FRAME_ERR] = rx_store & ~rx_s;
    ev[IRQ_TIMEOUT_ERR] = tx_abort;
    ev[IRQ_NOT_READY_ERR] = (wr_tx & ~modem_ok) | (rx_done & ~modem_ok);
    ev[IRQ_TX_DONE] = tx_busy_q_r & ~tx_busy;
  end

endmodule

/* File: testbench/serial_port_monitor.sv */
/*
  Port checker for the serial port top level.
  Assumes a bind to the top module and one clock domain.
*/
`timescale 1ns/1ps
module serial_port_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cts_i,
  input wire logic txd_o,
  input wire logic rts_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Counts the cycles that clear-to-send has been low.
  logic [3:0] cts_low_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || cts_i) begin
      cts_low_r <= 4'h0;
    end else if (cts_low_r != 4'hF) begin
      cts_low_r <= cts_low_r + 4'h1;
    end
  end

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  property p_ack_req;
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack missing");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_dat_idle;
    !wb_ack_o |-> (wb_dat_o == 32'h0);
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data not zero");
  property p_rst_out;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> txd_o && rts_o && !irq_o && !wb_ack_o;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("bad reset level");
  property p_start_len;
    $fell(txd_o) |-> !txd_o [*8];
  endproperty
  a_start_len: assert property (p_start_len) else $error("short start");
  property p_cts_hold;
    (cts_low_r >= 4'h5 && txd_o) |=> txd_o;
  endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("sent w/o cts");
  property p_abort;
    (cts_low_r == 4'h5) |-> txd_o;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");

  c_write: cover property (wb_ack_o && wb_we_i);
  c_start: cover property ($fell(txd_o));
  c_irq: cover property ($rose(irq_o));
endmodule

bind configurable_serial_port_ctl serial_port_monitor u_serial_port_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cts_i(cts_i), .txd_o(txd_o), .rts_o(rts_o), .irq_o(irq_o));

/* File: testbench/far_end.sv */
/*
  Far-end terminal model: samples frames off the port's line and
  sends frames back. Assumes the bench sets bit time and frame size.
*/
`timescale 1ns/1ps
module far_end (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  input int bit_cyc,
  input int frame_len
);
  logic [11:0] frames [$];
  int gaps [$];
  int now = 0;
  int last = 0;
  initial rxd_o = 1'b1;
  always @(posedge clk_i) now <= now + 1;

  initial begin
    logic [11:0] f;
    forever begin
      @(negedge txd_i);
      gaps.push_back(now - last);
      last = now;
      f = '0;
      repeat (bit_cyc / 2) @(posedge clk_i);
      for (int i = 0; i < frame_len; i++) begin
        f[i] = txd_i;
        if (i < frame_len - 1) repeat (bit_cyc) @(posedge clk_i);
      end
      frames.push_back(f);
    end
  end

  // Bit-timed frame; callers leave the turnaround.
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o <= f[i];
      repeat (bit_cyc) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask
endmodule

/* File: testbench/tb.sv */
/*
  Bench for the serial port: bus tasks and scenario sequence.
  Assumes the far-end model and a 200 kHz clock parameter.
*/
`timescale 1ns/1ps
module tb;
  import serial_port_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [4:0] wb_adr = 5'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, rxd, txd_o, rts_o, irq_o;
  logic cts = 1'b1;
  logic dsr = 1'b1;
  int bit_cyc = 10;
  int frame_len = 10;
  int mismatches = 0;
  int num_checks = 0;
  int ctl [5] = '{'h0F, 'hDF, 'h2B, 'h00, 'h00};
  int msw [5] = '{0, 0, 0, 0, 1};
  int nd [5] = '{8, 7, 8, 8, 8};
  int par [5] = '{0, 1, 2, 0, 0};
  int ns [5] = '{1, 2, 1, 2, 2};
  int len [5] = '{10, 11, 11, 11, 11};
  int bt [5] = '{10, 10, 41, 20, 666};
  int rc [4] = '{'h20F, 'h220F, 'h120F, 'h0F};
  logic [11:0] bad [3] = '{12'h000, 12'h100, 12'h200};
  logic [31:0] ex [3] = '{32'h1, 32'h3, 32'h5};

  always #10 clk_i = ~clk_i;

  configurable_serial_port_ctl #(.CLK_HZ(200000))
    u_configurable_serial_port_ctl (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd), .cts_i(cts),
    .dsr_i(dsr), .txd_o(txd_o), .rts_o(rts_o), .irq_o(irq_o));
  far_end u_far_end (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd),
    .bit_cyc(bit_cyc), .frame_len(frame_len));

  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_adr <= a;
    wb_we <= w;
    wb_dat <= d;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
    chk("ack", wb_ack_o, 1'b1);
    if (n == 20) summarize();
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input int d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic wait_tx(input int n);
    int k;
    for (k = 0; k < 40000 && u_far_end.frames.size() < n; k++) begin
      @(posedge clk_i);
    end
    chk("frames", u_far_end.frames.size() >= n, 1'b1);
    if (k == 40000) summarize();
  endtask

  task automatic restart(input int c);
    wr(OFS_CTRL, c);
    wr(OFS_IRQ_ST, 'h3F);
    u_far_end.frames.delete();
    u_far_end.gaps.delete();
  endtask

  function automatic logic [11:0] frm(input logic [7:0] c, input int m);
    logic [11:0] f;
    int k;
    f = '0;
    if (nd[m] == 7) c[7] = 1'b0;
    for (k = 0; k < nd[m]; k++) f[k + 1] = c[k];
    if (par[m] != 0) f[k + 1] = (^c) ^ (par[m] == 2);
    for (k = len[m] - ns[m]; k < len[m]; k++) f[k] = 1'b1;
    return f;
  endfunction

  initial begin
    int m;
    logic [11:0] f;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CTRL);
    chk("ctrl", q, 32'h0);
    wr(OFS_WAIT, 'h190);
    rd(OFS_WAIT);
    chk("wait", q, 32'h12C);
    for (m = 0; m < 5; m++) begin
      wr(OFS_MEMSW, msw[m]);
      bit_cyc = bt[m];
      frame_len = len[m];
      restart(ctl[m]);
      wr(OFS_TXDATA, 'hC3);
      repeat (5) @(posedge clk_i);
      wr(OFS_TXDATA, 'h3C);
      wait_tx(2);
      chk("f0", u_far_end.frames[0], frm(8'hC3, m));
      chk("f1", u_far_end.frames[1], frm(8'h3C, m));
      chk("gap", u_far_end.gaps[1] / bit_cyc, len[m]);
      repeat (2 * bit_cyc) @(posedge clk_i);
    end
    bit_cyc = 10;
    frame_len = 10;
    restart('h80F);
    wr(OFS_TXDATA, CHAR_CR);
    wait_tx(2);
    chk("lf", u_far_end.frames[1], frm(CHAR_LF, 0));
    repeat (30) @(posedge clk_i);
    restart('h0F);
    u_far_end.send(frm(CHAR_STOP, 0), 10);
    repeat (5) @(posedge clk_i);
    rd(OFS_STATUS);
    chk("pause", q[3], 1'b1);
    wr(OFS_TXDATA, 'h41);
    repeat (300) @(posedge clk_i);
    chk("held", u_far_end.frames.size(), 0);
    u_far_end.send(frm(CHAR_RESUME, 0), 10);
    wait_tx(1);
    chk("go", u_far_end.frames[0], frm(8'h41, 0));
    rd(OFS_IRQ_ST);
    chk("nostore", q[0], 1'b0);
    repeat (150) @(posedge clk_i);
    wr(OFS_CTRL, 'h10F);
    u_far_end.send(frm(CHAR_STOP, 0), 10);
    repeat (5) @(posedge clk_i);
    rd(OFS_RXDATA);
    chk("flowoff", q, CHAR_STOP);
    wr(OFS_IRQ_MASK, 'h01);
    f = frm(8'h56, 1);
    for (m = 0; m < 3; m++) begin
      restart('h1DF);
      u_far_end.send(f ^ bad[m], 11);
      repeat (5) @(posedge clk_i);
      rd(OFS_IRQ_ST);
      chk("rxerr", q, ex[m]);
      chk("irq", irq_o, 1'b1);
      rd(OFS_RXDATA);
      chk("rx", q, 32'h56);
    end
    wr(OFS_IRQ_MASK, 'h00);
    @(posedge clk_i);
    chk("mask", irq_o, 1'b0);
    wr(OFS_IRQ_MASK, 'h01);
    @(posedge clk_i);
    chk("unmask", irq_o, 1'b1);
    wr(OFS_IRQ_ST, 'h3F);
    @(posedge clk_i);
    chk("clear", irq_o, 1'b0);
    dsr <= 1'b0;
    restart('h0F);
    wr(OFS_TXDATA, 'h41);
    repeat (200) @(posedge clk_i);
    chk("dsrhold", u_far_end.frames.size(), 0);
    rd(OFS_IRQ_ST);
    chk("notrdy", q[4], 1'b1);
    wr(OFS_CTRL, 'h40F);
    wr(OFS_TXDATA, 'h42);
    wait_tx(1);
    chk("dsrskip", u_far_end.frames[0], frm(8'h42, 0));
    repeat (150) @(posedge clk_i);
    dsr <= 1'b1;
    cts <= 1'b0;
    restart('h0F);
    wr(OFS_TXDATA, 'hFF);
    repeat (200) @(posedge clk_i);
    chk("ctshold", u_far_end.frames.size(), 0);
    cts <= 1'b1;
    wait_tx(1);
    wr(OFS_TXDATA, 'hFF);
    repeat (30) @(posedge clk_i);
    cts <= 1'b0;
    repeat (20) @(posedge clk_i);
    rd(OFS_IRQ_ST);
    chk("timeout", q[3], 1'b1);
    wr(OFS_WAIT, 'h1);
    restart('h0F);
    wr(OFS_TXDATA, 'h55);
    repeat (19900) @(posedge clk_i);
    rd(OFS_IRQ_ST);
    chk("notyet", q[3], 1'b0);
    repeat (200) @(posedge clk_i);
    rd(OFS_IRQ_ST);
    chk("expired", q[3], 1'b1);
    cts <= 1'b1;
    for (m = 0; m < 4; m++) begin
      wr(OFS_CTRL, rc[m]);
      repeat (3) @(posedge clk_i);
      chk("rts", rts_o, m != 0);
    end
    summarize();
  end
endmodule
